// ==== logic/cmd_pkg.sv ====
package cmd_pkg;
	// ascii codes
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_QUOTE = 8'h22;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_SLASH = 8'h2F;
	// event bit positions
	localparam int EV_OPC = 0;
	localparam int EV_QRY = 2;
	localparam int EV_EXE = 4;
	localparam int EV_CME = 5;
	localparam int EV_PON = 7;
	localparam logic [7:0] EV_USED = 8'hB5;
	localparam logic [7:0] ESR_RESET = 8'h80;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// dotted decimal shape
	localparam int DD_FIELDS = 4;
	localparam int DD_DIGITS = 3;
	// command line buffer
	localparam int LINE_LEN = 32;
	localparam int ID_LEN = 41;
	// decoded common commands
	typedef enum logic [3:0] {
		CC_NONE = 4'h0, CC_CLS = 4'h1, CC_ESE = 4'h2, CC_ESEQ = 4'h3, CC_ESRQ = 4'h4,
		CC_IDNQ = 4'h5, CC_OPC = 4'h6, CC_OPCQ = 4'h7, CC_RST = 4'h8, CC_SRE = 4'h9,
		CC_SREQ = 4'hA, CC_BAD = 4'hF
	} ccmd_t;
	typedef enum logic [2:0] {
		ST_RECV = 3'b000, ST_DECODE = 3'b001, ST_EXEC = 3'b011, ST_WAIT = 3'b010,
		ST_REPLY = 3'b110
	} state_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} char_t;
endpackage : cmd_pkg

// ==== logic/common_command_status_parser.sv ====
// Overview of operation
// - A mnemonic that starts with an asterisk is handled here as a common command; others pass out.
// - A trailing question mark makes a query with a reply, except on CLS and RST where it is a command error; without it no reply is sent.
// - Commas and spaces inside quotes are not taken as parameter delimiters.
// - A dotted-decimal parameter has exactly four dot-separated fields of three digits each.
// - Clear resets status byte, event status and operation event bits and aborts pending work.
// - Clear touches only interface state; controller settings are restored only by reset.
// - Event bits weigh two to their position: 0 complete, 2 query, 4 execution, 5 command, 7 power.
// - The event enable command loads a decimal weight sum, masked to the used event bits, into the event enable mask.
// - The event enable query replies with the mask as a decimal weight sum and terminator.
// - The event status query replies with the decimal sum of the set event bits.
// - The identity query replies maker, model, slash-separated serials and n.n firmware version.
// - The complete command sets the complete bit only once pending operations have finished.
// - The complete query queues a 1 once pending operations finish, without setting the bit.
// - The reset command restores all monitor parameters to power-up values.
// - The service enable command loads a decimal weight sum into the service enable mask.
`timescale 1ns/1ns
module common_command_status_parser #(
	parameter int ID_LEN_P = cmd_pkg::ID_LEN,
	// identity text is arbitrary
	parameter logic [8*ID_LEN_P-1:0] ID_TEXT = "XMPL,DEVICE01,0000000/0000000/0000000,1.0"
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire cmd_pkg::char_t rx_char,
	input wire logic tx_ready,
	input wire logic ops_busy,
	input wire logic exe_error,
	input wire logic [7:0] status_byte_in,
	output cmd_pkg::char_t tx_char,
	output logic [7:0] esr_out,
	output logic [7:0] ese_out,
	output logic [7:0] sre_out,
	output logic clear_pulse,
	output logic reset_pulse,
	output logic abort_pulse,
	output logic dev_cmd_valid,
	output logic query_error_flag
);
	localparam int LL = cmd_pkg::LINE_LEN;

	// =====================================
	// line buffer
	logic [7:0] line_reg [LL];
	logic [5:0] len_reg;
	logic in_quote_reg;
	logic [5:0] param_reg;
	cmd_pkg::state_t state_reg;
	cmd_pkg::ccmd_t cmd_reg;
	logic [7:0] esr_reg, ese_reg, sre_reg;
	logic [7:0] num_reg;
	logic num_ok_reg;
	logic pend_opc_reg, pend_opcq_reg;
	logic [8*ID_LEN_P-1:0] reply_reg;
	logic [5:0] rlen_reg;
	logic [5:0] ridx_reg;
	logic is_term;
	assign is_term = rx_char.valid && (rx_char.data == cmd_pkg::CH_LF);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			len_reg <= 6'h00;
			in_quote_reg <= 1'b0;
		end else if (state_reg == cmd_pkg::ST_RECV && rx_char.valid && !is_term) begin
			if (rx_char.data == cmd_pkg::CH_QUOTE)
				in_quote_reg <= ~in_quote_reg;
			if (rx_char.data != cmd_pkg::CH_CR && len_reg < 6'(LL)) begin
				line_reg[len_reg[4:0]] <= rx_char.data;
				len_reg <= len_reg + 6'h01;
			end
		end else if (state_reg == cmd_pkg::ST_EXEC) begin
			len_reg <= 6'h00;
			in_quote_reg <= 1'b0;
		end
	end

	// =====================================
	// mnemonic decode
	function automatic logic [23:0] mn3(input logic [7:0] a, b, c);
		mn3 = {a & 8'hDF, b & 8'hDF, c & 8'hDF};
	endfunction : mn3

	cmd_pkg::ccmd_t dec;
	logic qry;
	always_comb begin
		dec = cmd_pkg::CC_BAD;
		qry = (len_reg >= 6'h05) && (line_reg[4] == cmd_pkg::CH_QMARK);
		unique case (mn3(line_reg[1], line_reg[2], line_reg[3]))
			"CLS": dec = qry ? cmd_pkg::CC_BAD : cmd_pkg::CC_CLS;
			"ESE": dec = qry ? cmd_pkg::CC_ESEQ : cmd_pkg::CC_ESE;
			"ESR": dec = qry ? cmd_pkg::CC_ESRQ : cmd_pkg::CC_BAD;
			"IDN": dec = qry ? cmd_pkg::CC_IDNQ : cmd_pkg::CC_BAD;
			"OPC": dec = qry ? cmd_pkg::CC_OPCQ : cmd_pkg::CC_OPC;
			"RST": dec = qry ? cmd_pkg::CC_BAD : cmd_pkg::CC_RST;
			"SRE": dec = qry ? cmd_pkg::CC_SREQ : cmd_pkg::CC_SRE;
			default: dec = cmd_pkg::CC_BAD;
		endcase
		if (len_reg < 6'h04 || line_reg[0] != cmd_pkg::CH_STAR)
			dec = cmd_pkg::CC_NONE;
	end

	// decimal parameter from position 5 on, digits accumulate until the value exceeds 255 and other characters are skipped
	logic [9:0] acc;
	logic acc_ok;
	always_comb begin
		acc = 10'h000;
		acc_ok = 1'b0;
		for (int i = 5; i < LL; i++) begin
			if (6'(i) < len_reg && line_reg[i] >= cmd_pkg::CH_ZERO
					&& line_reg[i] <= cmd_pkg::CH_NINE && acc < 10'd256) begin
				acc = 10'(acc * 10'd10) + {6'h00, 4'(line_reg[i] - cmd_pkg::CH_ZERO)};
				acc_ok = 1'b1;
			end
		end
		if (acc > 10'd255)
			acc_ok = 1'b0;
	end

	// dotted decimal shape check over the parameter field
	logic dd_ok;
	always_comb begin
		int f, d;
		f = 0;
		d = 0;
		dd_ok = 1'b1;
		for (int i = 0; i < LL; i++) begin
			if (6'(i) >= param_reg && 6'(i) < len_reg) begin
				if (line_reg[i] == cmd_pkg::CH_DOT) begin
					if (d != cmd_pkg::DD_DIGITS)
						dd_ok = 1'b0;
					f = f + 1;
					d = 0;
				end else
					d = d + 1;
			end
		end
		if (f != cmd_pkg::DD_FIELDS - 1 || d != cmd_pkg::DD_DIGITS)
			dd_ok = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			param_reg <= 6'h00;
		else if (state_reg == cmd_pkg::ST_RECV && rx_char.valid && !in_quote_reg
				&& (rx_char.data == cmd_pkg::CH_SPACE || rx_char.data == cmd_pkg::CH_COMMA))
			param_reg <= len_reg + 6'h01;
		else if (state_reg == cmd_pkg::ST_EXEC)
			param_reg <= 6'h00;
	end

	// =====================================
	// sequencer
	function automatic logic [23:0] dec3(input logic [7:0] v);
		dec3 = {cmd_pkg::CH_ZERO + 8'(v / 8'd100), cmd_pkg::CH_ZERO + 8'((v / 8'd10) % 8'd10),
			cmd_pkg::CH_ZERO + 8'(v % 8'd10)};
	endfunction : dec3

	logic [8*ID_LEN_P-1:0] reply_next;
	logic [5:0] rlen_next;
	always_comb begin
		reply_next = '0;
		rlen_next = 6'h00;
		unique case (cmd_reg)
			cmd_pkg::CC_ESEQ: begin
				reply_next[8*ID_LEN_P-1 -: 24] = dec3(ese_reg);
				rlen_next = 6'h03;
			end
			cmd_pkg::CC_ESRQ: begin
				reply_next[8*ID_LEN_P-1 -: 24] = dec3(esr_reg);
				rlen_next = 6'h03;
			end
			cmd_pkg::CC_SREQ: begin
				reply_next[8*ID_LEN_P-1 -: 24] = dec3(sre_reg);
				rlen_next = 6'h03;
			end
			cmd_pkg::CC_IDNQ: begin
				reply_next = ID_TEXT;
				rlen_next = 6'(ID_LEN_P);
			end
			cmd_pkg::CC_OPCQ: begin
				reply_next[8*ID_LEN_P-1 -: 8] = cmd_pkg::CH_ONE;
				rlen_next = 6'h01;
			end
			default: begin
				reply_next = '0;
				rlen_next = 6'h00;
			end
		endcase
	end

	logic tx_go;
	assign tx_go = state_reg == cmd_pkg::ST_REPLY && tx_ready;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= cmd_pkg::ST_RECV;
			cmd_reg <= cmd_pkg::CC_NONE;
			num_reg <= 8'h00;
			num_ok_reg <= 1'b0;
			ridx_reg <= 6'h00;
			rlen_reg <= 6'h00;
			reply_reg <= '0;
		end else begin
			unique case (state_reg)
				cmd_pkg::ST_RECV:
					if (is_term)
						state_reg <= cmd_pkg::ST_DECODE;
				cmd_pkg::ST_DECODE: begin
					cmd_reg <= dec;
					num_reg <= acc[7:0];
					num_ok_reg <= acc_ok;
					state_reg <= cmd_pkg::ST_EXEC;
				end
				cmd_pkg::ST_EXEC: begin
					reply_reg <= reply_next;
					rlen_reg <= rlen_next;
					ridx_reg <= 6'h00;
					if (cmd_reg == cmd_pkg::CC_OPC || cmd_reg == cmd_pkg::CC_OPCQ)
						state_reg <= cmd_pkg::ST_WAIT;
					else if (rlen_next != 6'h00)
						state_reg <= cmd_pkg::ST_REPLY;
					else
						state_reg <= cmd_pkg::ST_RECV;
				end
				cmd_pkg::ST_WAIT:
					if (!ops_busy)
						state_reg <= (cmd_reg == cmd_pkg::CC_OPCQ) ? cmd_pkg::ST_REPLY
							: cmd_pkg::ST_RECV;
				cmd_pkg::ST_REPLY:
					if (tx_go) begin
						ridx_reg <= ridx_reg + 6'h01;
						reply_reg <= reply_reg << 8;
						if (ridx_reg == rlen_reg + 6'h01)
							state_reg <= cmd_pkg::ST_RECV;
					end
			endcase
		end
	end

	// reply characters, then cr lf
	always_ff @(posedge core_clk) begin
		if (rst)
			tx_char <= '0;
		else if (tx_go) begin
			tx_char.valid <= 1'b1;
			tx_char.data <= (ridx_reg < rlen_reg) ? reply_reg[8*ID_LEN_P-1 -: 8]
				: (ridx_reg == rlen_reg) ? cmd_pkg::CH_CR : cmd_pkg::CH_LF;
		end else
			tx_char <= '0;
	end

	// =====================================
	// status registers
	logic in_exec;
	assign in_exec = state_reg == cmd_pkg::ST_EXEC;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			esr_reg <= cmd_pkg::ESR_RESET;
			ese_reg <= cmd_pkg::MASK_RESET;
			sre_reg <= cmd_pkg::MASK_RESET;
		end else begin
			if (in_exec && cmd_reg == cmd_pkg::CC_CLS)
				esr_reg <= 8'h00;
			else if (in_exec && cmd_reg == cmd_pkg::CC_ESRQ)
				esr_reg <= 8'h00;
			if (in_exec && cmd_reg == cmd_pkg::CC_ESE && num_ok_reg)
				ese_reg <= num_reg & cmd_pkg::EV_USED;
			if (in_exec && cmd_reg == cmd_pkg::CC_SRE && num_ok_reg)
				sre_reg <= num_reg;
			// events set after clear so a same-cycle event wins
			if (state_reg == cmd_pkg::ST_WAIT && !ops_busy && cmd_reg == cmd_pkg::CC_OPC)
				esr_reg[cmd_pkg::EV_OPC] <= 1'b1;
			if (exe_error || (in_exec && (cmd_reg == cmd_pkg::CC_ESE
					|| cmd_reg == cmd_pkg::CC_SRE) && !num_ok_reg && !dd_ok))
				esr_reg[cmd_pkg::EV_EXE] <= 1'b1;
			if (in_exec && cmd_reg == cmd_pkg::CC_BAD)
				esr_reg[cmd_pkg::EV_CME] <= 1'b1;
			if (tx_ready == 1'b0 && state_reg == cmd_pkg::ST_REPLY && is_term)
				esr_reg[cmd_pkg::EV_QRY] <= 1'b1;
		end
	end

	// =====================================
	// output strobes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clear_pulse <= 1'b0;
			reset_pulse <= 1'b0;
			abort_pulse <= 1'b0;
			dev_cmd_valid <= 1'b0;
			esr_out <= cmd_pkg::ESR_RESET;
			ese_out <= cmd_pkg::MASK_RESET;
			sre_out <= cmd_pkg::MASK_RESET;
			query_error_flag <= 1'b0;
		end else begin
			clear_pulse <= in_exec && cmd_reg == cmd_pkg::CC_CLS;
			abort_pulse <= in_exec && cmd_reg == cmd_pkg::CC_CLS;
			reset_pulse <= in_exec && cmd_reg == cmd_pkg::CC_RST;
			dev_cmd_valid <= in_exec && cmd_reg == cmd_pkg::CC_NONE;
			esr_out <= esr_reg;
			ese_out <= ese_reg;
			sre_out <= sre_reg & ~8'h40;
			query_error_flag <= esr_reg[cmd_pkg::EV_QRY];
		end
	end

	// =====================================
	// checks
	opc_wait_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == cmd_pkg::ST_WAIT && ops_busy) |=> !$rose(esr_reg[cmd_pkg::EV_OPC]))
		else $error("complete bit set while busy");
	cls_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && cmd_reg == cmd_pkg::CC_CLS && !exe_error) |=> esr_reg[7:5] == 3'b000)
		else $error("clear left event bits");
	cls_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && cmd_reg == cmd_pkg::CC_CLS) |=> clear_pulse && !reset_pulse)
		else $error("clear pulse wrong");
	rst_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && cmd_reg == cmd_pkg::CC_RST) |=> reset_pulse)
		else $error("reset pulse missing");
	ese_load_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && cmd_reg == cmd_pkg::CC_ESE && num_ok_reg)
		|=> ese_reg == ($past(num_reg) & cmd_pkg::EV_USED))
		else $error("event mask not loaded");
	sre_load_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && cmd_reg == cmd_pkg::CC_SRE && num_ok_reg) |=> sre_reg == $past(num_reg))
		else $error("service mask not loaded");
	term_decode_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == cmd_pkg::ST_RECV && is_term) |=> state_reg == cmd_pkg::ST_DECODE)
		else $error("terminator not taken");
	cmd_noreply_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_exec && (cmd_reg == cmd_pkg::CC_ESE || cmd_reg == cmd_pkg::CC_CLS))
		|=> state_reg == cmd_pkg::ST_RECV)
		else $error("command produced reply");
	opcq_bit_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == cmd_pkg::ST_WAIT && cmd_reg == cmd_pkg::CC_OPCQ && !ops_busy)
		|=> state_reg == cmd_pkg::ST_REPLY ##0 $stable(esr_reg[cmd_pkg::EV_OPC]))
		else $error("complete query misbehaved");
endmodule : common_command_status_parser

// ==== bench/host_model.sv ====
`timescale 1ns/1ns
module host_model (
	input wire logic core_clk,
	input wire cmd_pkg::char_t tx_char,
	output cmd_pkg::char_t rx_char,
	output logic tx_ready
);
	logic slow;
	logic line_done;
	string reply;
	initial begin
		rx_char = '0;
		tx_ready = 1'b1;
		slow = 1'b0;
		line_done = 1'b0;
		reply = "";
	end
	// ===========================================
	// reply side: slow mode takes every other char
	always @(posedge core_clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	always @(posedge core_clk) begin
		if (tx_char.valid) begin
			if (tx_char.data == cmd_pkg::CH_LF)
				line_done <= 1'b1;
			else if (tx_char.data != cmd_pkg::CH_CR)
				reply <= $sformatf("%s%c", reply, tx_char.data);
		end
	end
	// ===========================================
	// command side: one char per cycle, line closed by lf
	task automatic send_line(input string s, input bit term);
		reply = "";
		line_done = 1'b0;
		foreach (s[i]) begin
			@(posedge core_clk);
			rx_char <= '{1'b1, s[i]};
		end
		if (term) begin
			@(posedge core_clk);
			rx_char <= '{1'b1, cmd_pkg::CH_LF};
		end
		@(posedge core_clk);
		// released line shows no stale char
		rx_char <= '{1'b0, ~rx_char.data};
	endtask : send_line
endmodule : host_model

// ==== bench/common_command_status_parser_tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module common_command_status_parser_tb;
	typedef struct {string cmd; logic [319:0] rep; logic [7:0] ese; logic [7:0] esr;} row_t;
	// identity text is arbitrary
	localparam logic [263:0] ID = "ABCD,UNIT0001,0000001/0000002,9.9";
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ops_busy = 1'b0;
	logic exe_error = 1'b0;
	logic [7:0] status_byte_in = 8'h00;
	cmd_pkg::char_t rx_char, tx_char;
	logic tx_ready, clear_pulse, reset_pulse, abort_pulse, dev_cmd_valid, query_error_flag;
	logic [7:0] esr_out, ese_out, sre_out;
	int n_fail = 0, total_checks = 0, cycles = 0, n_clr = 0, n_abt = 0, n_rst = 0, n_dev = 0;
	row_t rows[13] = '{'{"*ESE 145", 0, 8'h91, 8'h80}, '{"*ESE?", "145", 8'h91, 8'h80},
		'{"*esr?", "128", 8'h91, 8'h00}, '{"*ESE 181", 0, 8'hB5, 8'h00},
		'{"*OPC?", "1", 8'hB5, 8'h00}, '{"*OPC", 0, 8'hB5, 8'h01},
		'{"*ESR?", "001", 8'hB5, 8'h00}, '{"*IDN?", ID, 8'hB5, 8'h00},
		'{"*SRE 16", 0, 8'hB5, 8'h00}, '{"*SRE?", "016", 8'hB5, 8'h00},
		'{"KRDG?", 0, 8'hB5, 8'h00}, '{"*XYZ", 0, 8'hB5, 8'h20}, '{"*CLS", 0, 8'hB5, 8'h00}};
	always #50 core_clk = ~core_clk;
	common_command_status_parser #(.ID_TEXT(ID), .ID_LEN_P(33)) common_command_status_parser_inst (
		.core_clk(core_clk), .rst(rst), .rx_char(rx_char), .tx_ready(tx_ready),
		.ops_busy(ops_busy), .exe_error(exe_error), .status_byte_in(status_byte_in),
		.tx_char(tx_char), .esr_out(esr_out), .ese_out(ese_out), .sre_out(sre_out),
		.clear_pulse(clear_pulse), .reset_pulse(reset_pulse), .abort_pulse(abort_pulse),
		.dev_cmd_valid(dev_cmd_valid), .query_error_flag(query_error_flag));
	host_model host_model_inst (.core_clk(core_clk), .tx_char(tx_char), .rx_char(rx_char),
		.tx_ready(tx_ready));
	function automatic logic [319:0] pk(input string s);
		pk = '0;
		foreach (s[i]) pk = {pk[311:0], s[i]};
	endfunction : pk
	always @(posedge core_clk) begin
		cycles++;
		if (!rst) begin
			n_clr += (clear_pulse === 1'b1);
			n_abt += (abort_pulse === 1'b1);
			n_rst += (reset_pulse === 1'b1);
			n_dev += (dev_cmd_valid === 1'b1);
		end
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic run_line(input string c, input logic [319:0] exp);
		int k;
		host_model_inst.send_line(c, 1'b1);
		k = 0;
		while (exp != 0 && !host_model_inst.line_done && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		repeat (6) @(posedge core_clk);
		`CHK(c, exp, pk(host_model_inst.reply))
	endtask : run_line
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// ===========================================
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("esr rst", 8'h80, esr_out)
		`CHK("ese rst", 8'h00, ese_out)
		`CHK("sre rst", 8'h00, sre_out)
		$display("test reset done");
		for (int i = 0; i < 13; i++) begin
			host_model_inst.slow = i[0];
			run_line(rows[i].cmd, rows[i].rep);
			`CHK("ese", rows[i].ese, ese_out)
			`CHK("esr", rows[i].esr, esr_out)
		end
		`CHK("sre", 8'h10, sre_out)
		`CHK("query flag", 1'b0, query_error_flag)
		`CHK("clear", 1, n_clr)
		`CHK("abort", 1, n_abt)
		`CHK("device line", 1, n_dev)
		$display("test table done");
		ops_busy <= 1'b1;
		run_line("*OPC", 0);
		repeat (20) @(posedge core_clk);
		`CHK("opc busy", 8'h00, esr_out)
		ops_busy <= 1'b0;
		repeat (8) @(posedge core_clk);
		`CHK("opc done", 8'h01, esr_out)
		ops_busy <= 1'b1;
		host_model_inst.send_line("*OPC?", 1'b1);
		repeat (20) @(posedge core_clk);
		`CHK("opcq busy", 320'h0, pk(host_model_inst.reply))
		ops_busy <= 1'b0;
		repeat (20) @(posedge core_clk);
		`CHK("opcq done", 320'h31, pk(host_model_inst.reply))
		exe_error <= 1'b1;
		@(posedge core_clk);
		exe_error <= 1'b0;
		repeat (4) @(posedge core_clk);
		`CHK("exe event", 8'h11, esr_out)
		$display("test completion done");
		host_model_inst.send_line("*RST", 1'b0);
		repeat (10) @(posedge core_clk);
		`CHK("rst unterminated", 0, n_rst)
		host_model_inst.send_line("", 1'b1);
		repeat (6) @(posedge core_clk);
		`CHK("rst pulse", 1, n_rst)
		$display("test terminator done");
		give_verdict();
	end
endmodule : common_command_status_parser_tb
